// ==== verilog/ssf_pkg.sv ====
// shared constants for the sensor status and fault register block
package ssf_pkg;
   // ----------------------------------------------------------------
   // register offsets and identifiers
   // ----------------------------------------------------------------
   localparam logic [15:0] CMD_OFFSET = 16'h001E;
   localparam logic [15:0] STATE_OFFSET = 16'h0022;
   localparam logic [15:0] FAULT_OFFSET = 16'h0024;
   localparam logic [15:0] EXT_FAULT_OFFSET = 16'h0026;
   localparam logic [15:0] MASK_OFFSET = 16'h0034;
   localparam logic [15:0] EXT_MASK_OFFSET = 16'h0036;
   localparam logic [15:0] STORED_MASK_OFFSET = 16'h0318;
   localparam logic [3:0] STATE_ID = 4'h8;
   localparam logic [3:0] FAULT_ID = 4'hA;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int POWER_ON_BIT = 11;
   localparam int SOFT_RESTART_BIT = 10;
   localparam int NEW_SAMPLE_BIT = 9;
   localparam int SUMMARY_BIT = 8;
   localparam int EXT_SUMMARY_BIT = 11;
   localparam int OVERRUN_BIT = 10;
   localparam int IFACE_BIT = 9;
   localparam int CRC_BIT = 8;
   localparam int IDLE_BIT = 7;
   localparam int CLEAR_RESET_FLAGS_BIT = 10;
   localparam int CLEAR_FAULT_BIT = 8;
   localparam int FAULT_EVENTS = 12;
   // ----------------------------------------------------------------
   // keys and reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] CLEAR_KEY = 8'h46;
   localparam logic [11:0] FAULT_RESET = 12'h000;
   // ----------------------------------------------------------------
   // processor state and phase codes
   // ----------------------------------------------------------------
   localparam logic [3:0] RUN_BOOTING = 4'h0;
   localparam logic [3:0] RUN_BOOTED = 4'h1;
   localparam logic [3:0] RUN_SELF_TEST = 4'hE;
   localparam logic [3:0] PHASE_IDLE = 4'h0;
   localparam logic [3:0] PHASE_ANGLES = 4'h1;
   localparam logic [3:0] PHASE_LOGIC_TEST = 4'h4;
   localparam logic [3:0] PHASE_ROM_SUM = 4'h6;
   localparam logic [3:0] PHASE_ARRAY_TEST = 4'h7;
   typedef enum logic [2:0] {
      SSF_BOOT = 3'b000,
      SSF_IDLE = 3'b001,
      SSF_RUN = 3'b010,
      SSF_LOGIC_TEST = 3'b011,
      SSF_ROM_SUM = 3'b100,
      SSF_ARRAY_TEST = 3'b101
   } ssf_cpu_t;
endpackage : ssf_pkg

// ==== verilog/ssf_sticky_bit.sv ====
// one sticky fault flag: event sets, clear resets, set wins
module ssf_sticky_bit (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic set_i,
   input wire logic clear_i,
   output logic flag_o
);
   logic flag_reg;
   logic flag_next;

   assign flag_next = set_i | (flag_reg & ~clear_i);

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         flag_reg <= 1'b0;
      end else begin
         flag_reg <= flag_next;
      end
   end

   assign flag_o = flag_reg;

   property p_set_wins;
      @(posedge ref_clk_i) disable iff (rst_i)
      set_i |=> flag_reg;
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("sticky flag missed a set");
endmodule : ssf_sticky_bit

// ==== verilog/ssf_status_regs.sv ====
// device-state and fault-flag registers of the angle sensor
module ssf_status_regs (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic power_on_rst_i,
   input wire logic hard_rst_i,
   input wire logic soft_rst_i,
   input wire logic cmd_wr_i,
   input wire logic [15:0] cmd_data_i,
   input wire logic mask_wr_i,
   input wire logic [15:0] mask_data_i,
   input wire logic [11:0] stored_fault_mask_i,
   input wire logic overrun_mask_bit_i,
   input wire logic [11:0] ext_fault_i,
   input wire logic [11:0] ext_mask_i,
   input wire logic angle_load_i,
   input wire logic angle_read_i,
   input wire logic ext_access_start_i,
   input wire logic ext_access_busy_i,
   input wire logic spi_frame_done_i,
   input wire logic [4:0] spi_bit_count_i,
   input wire logic spi_mosi_b15_i,
   input wire logic spi_crc_bad_i,
   input wire logic link_error_i,
   input wire logic acquire_timeout_i,
   input wire logic upper_angle_i,
   input wire logic lower_angle_i,
   input wire logic supply_high_i,
   input wire logic supply_low_i,
   input wire logic field_strong_i,
   input wire logic field_weak_i,
   input wire logic boot_done_i,
   input wire logic run_mode_i,
   input wire logic [1:0] self_test_sel_i,
   output logic spi_packet_drop_o,
   output logic [15:0] device_state_o,
   output logic [15:0] fault_flags_o
);
   // ----------------------------------------------------------------
   // reset-event flags and command decode
   // ----------------------------------------------------------------
   logic clear_reset_flags_cmd;
   logic clear_fault_cmd;
   logic fault_clear;
   logic power_on_reg;
   logic power_on_next;
   logic soft_restart_flag_reg;
   logic soft_restart_flag_next;
   logic new_sample_flag_reg;
   logic new_sample_flag_next;
   logic [11:0] mask_reg;
   logic [11:0] mask_next;
   logic any_reset;

   // power-on and hard resets act like the block reset for fault state
   assign any_reset = rst_i | power_on_rst_i | hard_rst_i;

   assign clear_reset_flags_cmd = cmd_wr_i & cmd_data_i[ssf_pkg::CLEAR_RESET_FLAGS_BIT]
      & (cmd_data_i[7:0] == ssf_pkg::CLEAR_KEY);
   assign clear_fault_cmd = cmd_wr_i & cmd_data_i[ssf_pkg::CLEAR_FAULT_BIT]
      & (cmd_data_i[7:0] == ssf_pkg::CLEAR_KEY);
   assign fault_clear = clear_fault_cmd | power_on_rst_i | hard_rst_i;

   // power-on sets, keyed clear resets; set wins
   assign power_on_next = power_on_rst_i | (power_on_reg & ~clear_reset_flags_cmd);
   // soft restart sets, keyed clear resets
   assign soft_restart_flag_next = soft_rst_i
      | (soft_restart_flag_reg & ~clear_reset_flags_cmd);
   // load sets, host read clears; a fresh load wins
   assign new_sample_flag_next = angle_load_i | (new_sample_flag_reg & ~angle_read_i);
   assign mask_next = mask_wr_i ? mask_data_i[11:0] : mask_reg;

   // the reset flags survive the block reset so that software can see it
   always_ff @(posedge ref_clk_i) begin
      power_on_reg <= power_on_next;
      soft_restart_flag_reg <= soft_restart_flag_next;
   end

   always_ff @(posedge ref_clk_i) begin
      if (any_reset) begin
         new_sample_flag_reg <= 1'b0;
         mask_reg <= ssf_pkg::FAULT_RESET;
      end else begin
         new_sample_flag_reg <= new_sample_flag_next;
         mask_reg <= mask_next;
      end
   end

   // ----------------------------------------------------------------
   // fault events
   // ----------------------------------------------------------------
   logic [10:0] fault_event;
   logic [10:0] fault_flag;
   logic [11:0] fault_live;
   logic ext_summary;
   logic spi_bad_count;

   // per-bit extended masks only; the whole-register mask is not applied
   assign ext_summary = |(ext_fault_i & ~ext_mask_i);
   // a 16-bit frame is the only legal length
   assign spi_bad_count = spi_bit_count_i != 5'h10;
   // bad packets are discarded by the framing logic
   assign spi_packet_drop_o = spi_frame_done_i & (spi_bad_count | spi_mosi_b15_i | spi_crc_bad_i);

   // overrun when a new access starts while busy
   assign fault_event[ssf_pkg::OVERRUN_BIT] = ext_access_start_i & ext_access_busy_i;
   assign fault_event[ssf_pkg::IFACE_BIT] = (spi_frame_done_i & (spi_bad_count | spi_mosi_b15_i))
      | link_error_i;
   assign fault_event[ssf_pkg::CRC_BIT] = spi_frame_done_i & spi_crc_bad_i;
   assign fault_event[ssf_pkg::IDLE_BIT] = ~run_mode_i;
   assign fault_event[6] = acquire_timeout_i;
   assign fault_event[5] = upper_angle_i;
   assign fault_event[4] = lower_angle_i;
   assign fault_event[3] = supply_high_i;
   assign fault_event[2] = supply_low_i;
   assign fault_event[1] = field_strong_i;
   assign fault_event[0] = field_weak_i;

   // sticky flag per bit; the extended summary stays live, not stored
   genvar gi;
   generate
      for (gi = 0; gi < ssf_pkg::EXT_SUMMARY_BIT; gi++) begin : g_fault
         ssf_sticky_bit u_flag (
            .ref_clk_i(ref_clk_i),
            .rst_i(rst_i),
            .set_i(fault_event[gi]),
            .clear_i(fault_clear),
            .flag_o(fault_flag[gi])
         );
      end
   endgenerate

   // the extended summary follows the live condition, the idle bit is live or sticky, others are the sticky flags
   assign fault_live[11] = ext_summary;
   assign fault_live[10:8] = fault_flag[10:8];
   assign fault_live[7] = ~run_mode_i | fault_flag[7];
   assign fault_live[6:0] = fault_flag[6:0];

   // ----------------------------------------------------------------
   // processor state machine
   // ----------------------------------------------------------------
   ssf_pkg::ssf_cpu_t cpu_reg;
   ssf_pkg::ssf_cpu_t cpu_next;

   always_comb begin
      cpu_next = cpu_reg;
      case (cpu_reg)
         ssf_pkg::SSF_BOOT: begin
            if (boot_done_i) begin
               cpu_next = ssf_pkg::SSF_IDLE;
            end
         end
         ssf_pkg::SSF_IDLE,
         ssf_pkg::SSF_RUN,
         ssf_pkg::SSF_LOGIC_TEST,
         ssf_pkg::SSF_ROM_SUM,
         ssf_pkg::SSF_ARRAY_TEST: begin
            case (self_test_sel_i)
               2'h1: cpu_next = ssf_pkg::SSF_LOGIC_TEST;
               2'h2: cpu_next = ssf_pkg::SSF_ROM_SUM;
               2'h3: cpu_next = ssf_pkg::SSF_ARRAY_TEST;
               default: cpu_next = run_mode_i ? ssf_pkg::SSF_RUN : ssf_pkg::SSF_IDLE;
            endcase
         end
         default: cpu_next = ssf_pkg::SSF_BOOT;
      endcase
   end

   // a soft restart reboots the processor but keeps fault state
   always_ff @(posedge ref_clk_i) begin
      if (any_reset | soft_rst_i) begin
         cpu_reg <= ssf_pkg::SSF_BOOT;
      end else begin
         cpu_reg <= cpu_next;
      end
   end

   logic [3:0] run_state;
   logic [3:0] phase;

   assign run_state = (cpu_reg == ssf_pkg::SSF_BOOT) ? ssf_pkg::RUN_BOOTING
      : (cpu_reg == ssf_pkg::SSF_IDLE || cpu_reg == ssf_pkg::SSF_RUN) ? ssf_pkg::RUN_BOOTED
      : ssf_pkg::RUN_SELF_TEST;
   assign phase = (cpu_reg == ssf_pkg::SSF_RUN) ? ssf_pkg::PHASE_ANGLES
      : (cpu_reg == ssf_pkg::SSF_LOGIC_TEST) ? ssf_pkg::PHASE_LOGIC_TEST
      : (cpu_reg == ssf_pkg::SSF_ROM_SUM) ? ssf_pkg::PHASE_ROM_SUM
      : (cpu_reg == ssf_pkg::SSF_ARRAY_TEST) ? ssf_pkg::PHASE_ARRAY_TEST
      : ssf_pkg::PHASE_IDLE;

   // ----------------------------------------------------------------
   // read data
   // ----------------------------------------------------------------
   logic [11:0] eff_mask;
   logic summary;
   logic [15:0] state_word;
   logic [15:0] fault_word;

   // either mask source excludes a flag; overrun has its own stored mask
   assign eff_mask = mask_reg | stored_fault_mask_i
      | {1'b0, overrun_mask_bit_i, 10'h000};
   assign summary = |(fault_live & ~eff_mask);
   assign state_word = {ssf_pkg::STATE_ID, power_on_reg, soft_restart_flag_reg,
      new_sample_flag_reg, summary, run_state, phase};
   assign fault_word = {ssf_pkg::FAULT_ID, fault_live};

   logic [15:0] state_out_reg;
   logic [15:0] fault_out_reg;

   always_ff @(posedge ref_clk_i) begin
      state_out_reg <= state_word;
      fault_out_reg <= fault_word;
   end

   assign device_state_o = state_out_reg;
   assign fault_flags_o = fault_out_reg;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_ids;
      @(posedge ref_clk_i) disable iff (rst_i)
      ##1 (device_state_o[15:12] == 4'h8) && (fault_flags_o[15:12] == 4'hA);
   endproperty
   a_ids: assert property (p_ids) else $error("identifier wrong");

   property p_power_on;
      @(posedge ref_clk_i) power_on_rst_i |=> ##1 device_state_o[11];
   endproperty
   a_power_on: assert property (p_power_on) else $error("power-on flag not set");

   property p_soft;
      @(posedge ref_clk_i) soft_rst_i |=> ##1 device_state_o[10];
   endproperty
   a_soft: assert property (p_soft) else $error("soft flag not set");

   property p_clear_flags;
      @(posedge ref_clk_i) disable iff (rst_i)
      (clear_reset_flags_cmd && !power_on_rst_i && !soft_rst_i) |=> ##1 !device_state_o[11]
         && !device_state_o[10];
   endproperty
   a_clear_flags: assert property (p_clear_flags) else $error("reset flags not cleared");

   property p_new_sample;
      @(posedge ref_clk_i) disable iff (any_reset)
      angle_load_i |=> ##1 device_state_o[9];
   endproperty
   a_new_sample: assert property (p_new_sample) else $error("new-sample flag missing");

   property p_sample_read;
      @(posedge ref_clk_i) disable iff (any_reset)
      (angle_read_i && !angle_load_i) |=> ##1 !device_state_o[9];
   endproperty
   a_sample_read: assert property (p_sample_read) else $error("new-sample not cleared");

   property p_crc;
      @(posedge ref_clk_i) disable iff (any_reset)
      (spi_frame_done_i && spi_crc_bad_i) |=> ##1 fault_flags_o[8];
   endproperty
   a_crc: assert property (p_crc) else $error("crc flag not set");

   property p_sticky;
      @(posedge ref_clk_i) disable iff (any_reset)
      (fault_flags_o[2] && !$past(fault_clear) && !$past(rst_i)) |=> fault_flags_o[2];
   endproperty
   a_sticky: assert property (p_sticky) else $error("undervoltage flag dropped");

   property p_clear_fault;
      @(posedge ref_clk_i) disable iff (rst_i)
      (clear_fault_cmd && !supply_high_i) |=> ##1 !fault_flags_o[3];
   endproperty
   a_clear_fault: assert property (p_clear_fault) else $error("fault not cleared");

   property p_not_run;
      @(posedge ref_clk_i) disable iff (rst_i)
      !run_mode_i |=> fault_flags_o[7] == 1'b1 || $past(rst_i);
   endproperty
   a_not_run: assert property (p_not_run) else $error("not-run flag clear");

   property p_summary;
      @(posedge ref_clk_i) disable iff (rst_i)
      ##1 device_state_o[8] == |($past(fault_live) & ~$past(eff_mask));
   endproperty
   a_summary: assert property (p_summary) else $error("summary mismatch");

   property p_overrun;
      @(posedge ref_clk_i) disable iff (any_reset)
      (ext_access_start_i && ext_access_busy_i) |=> ##1 fault_flags_o[10];
   endproperty
   a_overrun: assert property (p_overrun) else $error("overrun flag not set");

   property p_ext_summary;
      @(posedge ref_clk_i) disable iff (rst_i)
      (|(ext_fault_i & ~ext_mask_i)) |=> fault_flags_o[11];
   endproperty
   a_ext_summary: assert property (p_ext_summary) else $error("ext summary clear");

   property p_boot;
      @(posedge ref_clk_i) (any_reset || soft_rst_i) |=> ##1 device_state_o[7:4] == 4'h0;
   endproperty
   a_boot: assert property (p_boot) else $error("state not booting after reset");

   property p_bad_key;
      @(posedge ref_clk_i) disable iff (any_reset)
      (cmd_wr_i && (cmd_data_i[7:0] != 8'h46) && !any_reset) |=> fault_flags_o[1]
         |=> fault_flags_o[1];
   endproperty
   a_bad_key: assert property (p_bad_key) else $error("unkeyed command cleared");
endmodule : ssf_status_regs

// ==== testbench/ssf_host_model.sv ====
// host controller model: writes the command and mask registers
module ssf_host_model (
   input wire logic ref_clk_i,
   output logic cmd_wr_o,
   output logic [15:0] cmd_data_o,
   output logic mask_wr_o,
   output logic [15:0] mask_data_o
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      cmd_wr_o = 1'b0;
      cmd_data_o = 16'h5A5A;
      mask_wr_o = 1'b0;
      mask_data_o = 16'hA5A5;
   end

   task automatic send_cmd(input logic clr_rst, input logic clr_flt, input logic [7:0] key);
      @(posedge ref_clk_i);
      cmd_wr_o <= 1'b1;
      cmd_data_o <= {5'h00, clr_rst, 1'b0, clr_flt, key};
      @(posedge ref_clk_i);
      cmd_wr_o <= 1'b0;
      // data means nothing once the strobe drops, so it is scrambled
      cmd_data_o <= ~cmd_data_o;
   endtask : send_cmd

   task automatic write_mask(input logic [11:0] msk);
      @(posedge ref_clk_i);
      mask_wr_o <= 1'b1;
      mask_data_o <= {4'h0, msk};
      @(posedge ref_clk_i);
      mask_wr_o <= 1'b0;
      mask_data_o <= ~mask_data_o;
   endtask : write_mask
endmodule : ssf_host_model

// ==== testbench/ssf_status_regs_bench.sv ====
// self-checking bench for the status and fault register block
module ssf_status_regs_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk_i, rst_i, cmd_wr, mask_wr, mosi_b15, crc_bad, busy, ovr_mask;
   logic boot_done, run_mode, drop;
   logic [15:0] ev, cmd_data, mask_data, device_state_o, fault_flags_o;
   logic [11:0] stored_mask, ext_fault, ext_mask;
   logic [4:0] bit_cnt;
   logic [1:0] test_sel;
   int num_errors = 0;
   int checks_done = 0;
   // boot, run, select, expected state and phase
   localparam logic [11:0] MODES [6] = '{12'h810, 12'hC11, 12'hDE4, 12'hEE6, 12'hFE7, 12'hC11};

   ssf_host_model host (.ref_clk_i(ref_clk_i), .cmd_wr_o(cmd_wr), .cmd_data_o(cmd_data),
      .mask_wr_o(mask_wr), .mask_data_o(mask_data));
   ssf_status_regs dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .power_on_rst_i(ev[11]),
      .hard_rst_i(ev[12]), .soft_rst_i(ev[10]), .cmd_wr_i(cmd_wr), .cmd_data_i(cmd_data),
      .mask_wr_i(mask_wr), .mask_data_i(mask_data), .stored_fault_mask_i(stored_mask),
      .overrun_mask_bit_i(ovr_mask), .ext_fault_i(ext_fault), .ext_mask_i(ext_mask),
      .angle_load_i(ev[8]), .angle_read_i(ev[9]), .ext_access_start_i(ev[14]),
      .ext_access_busy_i(busy), .spi_frame_done_i(ev[13]), .spi_bit_count_i(bit_cnt),
      .spi_mosi_b15_i(mosi_b15), .spi_crc_bad_i(crc_bad), .link_error_i(ev[7]),
      .acquire_timeout_i(ev[6]), .upper_angle_i(ev[5]), .lower_angle_i(ev[4]),
      .supply_high_i(ev[3]), .supply_low_i(ev[2]), .field_strong_i(ev[1]),
      .field_weak_i(ev[0]), .boot_done_i(boot_done), .run_mode_i(run_mode),
      .self_test_sel_i(test_sel), .spi_packet_drop_o(drop), .device_state_o(device_state_o),
      .fault_flags_o(fault_flags_o));

   initial begin
      ref_clk_i = 1'b0;
      forever #10 ref_clk_i = ~ref_clk_i;
   end

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic finish_test;
      if (num_errors == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : finish_test

   task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   // outputs trail their cause by two edges, three for boot through idle into run; three edges just cover it
   task automatic settle;
      repeat (3) @(posedge ref_clk_i);
      #1;
   endtask : settle

   task automatic pulse(input int b);
      @(posedge ref_clk_i);
      ev[b] <= 1'b1;
      @(posedge ref_clk_i);
      ev[b] <= 1'b0;
   endtask : pulse

   task automatic expect_fault(input string nm, input logic [15:0] exp);
      settle();
      check(nm, fault_flags_o, exp);
      host.send_cmd(1'b0, 1'b1, ssf_pkg::CLEAR_KEY);
      settle();
      check(nm, fault_flags_o, 16'hA000);
   endtask : expect_fault

   task automatic spi_frame(input logic [4:0] n, input logic b15, input logic crc,
      input logic exp_drop, input logic [15:0] exp);
      @(posedge ref_clk_i);
      bit_cnt <= n;
      mosi_b15 <= b15;
      crc_bad <= crc;
      ev[13] <= 1'b1;
      #1;
      check("drop", {15'h0, drop}, {15'h0, exp_drop});
      @(posedge ref_clk_i);
      ev[13] <= 1'b0;
      bit_cnt <= 5'h10;
      mosi_b15 <= 1'b0;
      crc_bad <= 1'b0;
      expect_fault("spi", exp);
   endtask : spi_frame

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_modes;
      settle();
      // soft flag is left out: its value after power-up is not pinned down
      check("state", device_state_o & 16'hFBFF, 16'h8900);
      check("faults", fault_flags_o, 16'hA080);
      foreach (MODES[k]) begin
         @(posedge ref_clk_i);
         {boot_done, run_mode, test_sel} <= MODES[k][11:8];
         settle();
         check("mode", {8'h0, device_state_o[7:0]}, {8'h0, MODES[k][7:0]});
      end
      expect_fault("run", 16'hA080);
      check("summary", {15'h0, device_state_o[8]}, 16'h0000);
   endtask : t_modes

   task automatic t_events;
      for (int i = 0; i < 7; i++) begin
         pulse(i);
         settle();
         check("summary", {15'h0, device_state_o[8]}, 16'h0001);
         expect_fault("event", 16'hA000 | (16'h0001 << i));
      end
   endtask : t_events

   task automatic t_iface;
      spi_frame(5'h10, 1'b0, 1'b0, 1'b0, 16'hA000);
      spi_frame(5'h0F, 1'b0, 1'b0, 1'b1, 16'hA200);
      spi_frame(5'h11, 1'b0, 1'b0, 1'b1, 16'hA200);
      spi_frame(5'h10, 1'b1, 1'b0, 1'b1, 16'hA200);
      spi_frame(5'h10, 1'b0, 1'b1, 1'b1, 16'hA100);
      pulse(7);
      expect_fault("link", 16'hA200);
      pulse(14);
      expect_fault("start", 16'hA000);
      @(posedge ref_clk_i);
      busy <= 1'b1;
      pulse(14);
      expect_fault("overrun", 16'hA400);
   endtask : t_iface

   task automatic t_masks;
      host.write_mask(12'h004);
      pulse(2);
      settle();
      check("mask", {15'h0, device_state_o[8]}, 16'h0000);
      expect_fault("masked", 16'hA004);
      host.write_mask(12'h000);
      stored_mask <= 12'h008;
      pulse(3);
      settle();
      check("stored", {15'h0, device_state_o[8]}, 16'h0000);
      @(posedge ref_clk_i);
      stored_mask <= 12'h000;
      expect_fault("stored", 16'hA008);
      @(posedge ref_clk_i);
      ovr_mask <= 1'b1;
      pulse(14);
      settle();
      check("ovr", {15'h0, device_state_o[8]}, 16'h0000);
      expect_fault("ovr", 16'hA400);
      @(posedge ref_clk_i);
      busy <= 1'b0;
      ovr_mask <= 1'b0;
      ext_fault <= 12'h001;
      settle();
      check("ext", {device_state_o[8], fault_flags_o[14:0]}, 16'hA800);
      @(posedge ref_clk_i);
      ext_mask <= 12'h001;
      settle();
      check("ext", fault_flags_o, 16'hA000);
      @(posedge ref_clk_i);
      ext_fault <= 12'h000;
      ext_mask <= 12'h000;
   endtask : t_masks

   task automatic t_resets;
      pulse(10);
      settle();
      check("soft", {14'h0, device_state_o[11:10]}, 16'h0003);
      host.send_cmd(1'b1, 1'b0, ssf_pkg::CLEAR_KEY);
      settle();
      check("clr", {14'h0, device_state_o[11:10]}, 16'h0000);
      pulse(4);
      settle();
      pulse(11);
      settle();
      check("por", {14'h0, device_state_o[11], fault_flags_o[4]}, 16'h0002);
      pulse(5);
      settle();
      pulse(12);
      settle();
      check("hard", {15'h0, fault_flags_o[5]}, 16'h0000);
      repeat (2) settle();
      host.send_cmd(1'b1, 1'b1, ssf_pkg::CLEAR_KEY);
      settle();
      check("both", {device_state_o[11:10], fault_flags_o[13:0]}, 16'h2000);
      pulse(8);
      settle();
      check("sample", {15'h0, device_state_o[9]}, 16'h0001);
      pulse(9);
      settle();
      check("sample", {15'h0, device_state_o[9]}, 16'h0000);
   endtask : t_resets

   task automatic t_race;
      fork
         host.send_cmd(1'b0, 1'b1, ssf_pkg::CLEAR_KEY);
         pulse(1);
      join
      host.send_cmd(1'b0, 1'b1, 8'hB9);
      expect_fault("race", 16'hA002);
   endtask : t_race

   // block reset mid-run: faults, mask and new-sample clear, reset flags stay
   task automatic t_block_reset;
      pulse(11);
      pulse(10);
      host.write_mask(12'h004);
      pulse(2);
      pulse(8);
      settle();
      check("pre", {device_state_o[11:8], fault_flags_o[11:0]}, 16'hE004);
      @(posedge ref_clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      settle();
      check("rst", device_state_o, 16'h8C11);
      check("rst", fault_flags_o, 16'hA000);
      pulse(2);
      settle();
      check("rst", {15'h0, device_state_o[8]}, 16'h0001);
      expect_fault("rst", 16'hA004);
   endtask : t_block_reset

   initial begin
      rst_i = 1'b1;
      ev = 16'h0800;
      {mosi_b15, crc_bad, busy, ovr_mask, boot_done, run_mode} = 6'h00;
      {stored_mask, ext_fault, ext_mask} = 36'h0;
      bit_cnt = 5'h10;
      test_sel = 2'h0;
      repeat (10) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      ev <= 16'h0000;
      t_modes();
      t_events();
      t_iface();
      t_masks();
      t_resets();
      t_race();
      t_block_reset();
      finish_test();
   end

   // the sequence needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge ref_clk_i);
      num_errors++;
      finish_test();
   end
endmodule : ssf_status_regs_bench
